// file: core/osc_sel_pkg.sv
// Purpose: Shared constants and types for the oscillator select and sync control block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes:   Reserved fields are not stored and read as zero.
package osc_sel_pkg;

  // Register word indices and their byte addresses.
  localparam logic [11:0] IDX_SYNC_CTRL  = 12'h300;
  localparam logic [11:0] IDX_SW_SELECT  = 12'h301;
  localparam logic [11:0] IDX_BANK_CFG   = 12'h303;
  localparam logic [11:0] IDX_ENABLE     = 12'h308;
  localparam logic [11:0] IDX_SW_SYNC    = 12'h310;
  localparam logic [11:0] IDX_STATUS     = 12'h312;
  localparam logic [13:0] ADDR_SYNC_CTRL = {IDX_SYNC_CTRL, 2'h0};
  localparam logic [13:0] ADDR_SW_SELECT = {IDX_SW_SELECT, 2'h0};
  localparam logic [13:0] ADDR_BANK_CFG  = {IDX_BANK_CFG, 2'h0};
  localparam logic [13:0] ADDR_ENABLE    = {IDX_ENABLE, 2'h0};
  localparam logic [13:0] ADDR_SW_SYNC   = {IDX_SW_SYNC, 2'h0};
  localparam logic [13:0] ADDR_STATUS    = {IDX_STATUS, 2'h0};

  // Field positions.
  localparam int SRC_B_BIT     = 5;
  localparam int SRC_A_BIT     = 4;
  localparam int PHASE_SRC_LSB = 0;
  localparam int SEL_B_LSB     = 8;
  localparam int SEL_A_LSB     = 0;
  localparam int SEL_W         = 5;
  localparam int ENABLE_BIT    = 0;
  localparam int SW_SYNC_BIT   = 0;
  localparam int STAT_A_LSB    = 0;
  localparam int STAT_B_LSB    = 8;
  localparam int STAT_ARM_BIT  = 16;

  // Reset values.
  localparam logic [7:0]  RST_SYNC_CTRL = 8'h00;
  localparam logic [15:0] RST_SW_SELECT = 16'h0000;
  localparam logic [1:0]  RST_BANK_CFG  = 2'h0;
  localparam logic        RST_ENABLE    = 1'b0;
  localparam logic        RST_SW_SYNC   = 1'b0;
  localparam logic [4:0]  RST_ACC_SEL   = 5'h00;

  // Phase reset source encodings.
  localparam logic [1:0] PHASE_IMMEDIATE = 2'h0;
  localparam logic [1:0] PHASE_SYSREF    = 2'h1;
  localparam logic [1:0] PHASE_TRIGGER   = 2'h2;

  // Bank select mode encodings.
  localparam logic [1:0] BANK_SPLIT  = 2'h0;
  localparam logic [1:0] BANK_SHARED = 2'h1;
  localparam logic [1:0] BANK_STEER  = 2'h2;

  typedef enum logic [2:0] {
    SYNC_IDLE        = 3'b001,
    SYNC_WAIT_SYSREF = 3'b010,
    SYNC_WAIT_TRIG   = 3'b100
  } sync_state_t;

endpackage

// file: core/edge_sync.sv
// Purpose: Two-flop synchroniser with rising edge detection for a group of pins.
// Assumes: Inputs are asynchronous to hclk.
// Notes:   The edge compares the second stage with a third copy, never the first stage.
`timescale 1ns/1ps
module edge_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Pins and synchronised results
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] level_ff;
  logic [W-1:0] prev_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_ff  <= '0;
      level_ff <= '0;
      prev_ff  <= '0;
    end
    else
    begin
      meta_ff  <= pin;
      level_ff <= meta_ff;
      prev_ff  <= level_ff; // R20
    end
  end

  assign level = level_ff;
  assign rise  = level_ff & ~prev_ff; // R20

endmodule // edge_sync

// file: core/oscillator_select_sync_ctrl.sv
// Purpose: Chooses the accumulator of oscillators A and B and times their accumulator reset.
// Assumes: AHB-Lite single word transfers; external select pins are asynchronous.
// Notes:   Zero wait states; unmapped reads inside the map return zero, reads above it keep the last read data; unmapped writes are dropped.
//
// Overview of operation
// [R1] Source 0 for B: B follows software index field.
// [R2] Source 1 for B: B taken from external index and bank on strobe rise.
// [R3] Source 0 for A: A follows software index field.
// [R4] Source 1 for A: A taken from external index and bank on strobe rise.
// [R5] External driver changes index and bank together with the strobe.
// [R6] Phase source 0: sync pulse resets both accumulators at once.
// [R7] Phase source 1: sync pulse arms reset for next SYSREF rising edge.
// [R8] Phase source 2: arm reset for next strobe rise with bank high; 3 reserved.
// [R9] B software index is bits 12 to 8, top bit picks bank.
// [R10] A software index is bits 4 to 0, top bit picks bank.
// [R11] Bank mode 0: sampled index selects within each channel's own bank.
// [R12] Bank mode 1: both take same accumulator, bank pin is top bit.
// [R13] Bank mode 2: strobe updates only oscillator named by bank pin; 3 reserved.
// [R14] Enable bit 0 runs oscillators; cleared holds all oscillator logic in reset.
// [R15] Software sets enable only after configuration and with datapath enabled.
// [R16] Software changes sync and select source only while disabled.
// [R17] Software changes bank mode only while disabled.
// [R18] One SYSREF edge cannot both align FIFO and reset accumulators.
// [R19] Writing one over a zero fires sync; reads return last written value.
// [R20] Strobe and SYSREF edges found by comparing successive synchronised samples.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module oscillator_select_sync_ctrl
  import osc_sel_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // External select pins
  input  wire logic [3:0]  ext_select_index,
  input  wire logic        ext_bank_select,
  input  wire logic        ext_select_strobe,
  input  wire logic        sysref,
  // Oscillator control
  output logic      [4:0]  osc_a_acc_sel,
  output logic      [4:0]  osc_b_acc_sel,
  output logic             acc_reset
);

  logic [7:0]  sync_ctrl_ff;
  logic [15:0] sw_select_ff;
  logic [1:0]  bank_cfg_ff;
  logic        enable_ff;
  logic        sw_sync_ff;
  logic        wr_pend_ff;
  logic [13:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic        sync_fire_ff;
  logic [4:0]  a_sel_ff;
  logic [4:0]  b_sel_ff;
  logic        acc_reset_ff;
  sync_state_t sync_state_ff;
  logic [3:0]  idx_s;
  logic        bank_s;
  logic        strobe_rise;
  logic        strobe_lvl;
  logic [4:0]  pin_rise;
  logic        sysref_rise;
  logic        addr_ok;
  logic        src_a;
  logic        src_b;
  logic [1:0]  phase_src;

  assign src_a     = sync_ctrl_ff[SRC_A_BIT];
  assign src_b     = sync_ctrl_ff[SRC_B_BIT];
  assign phase_src = sync_ctrl_ff[PHASE_SRC_LSB +: 2];
  // Decode covers the whole address so aliases above the map stay unmapped.
  assign addr_ok   = hsel && htrans[1] && hready && (haddr[31:14] == 18'h00000);

  // Index, bank and strobe share one synchroniser so they stay aligned in time.
  edge_sync #(.W(6)) u_sel_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     ({ext_select_strobe, ext_bank_select, ext_select_index}),
    .level   ({strobe_lvl, bank_s, idx_s}), // R5
    .rise    ({strobe_rise, pin_rise})
  );

  edge_sync #(.W(1)) u_sysref_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (sysref),
    .level   (),
    .rise    (sysref_rise) // R20
  );

  function automatic logic [31:0] read_value(input logic [13:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == ADDR_SYNC_CTRL)
      v[7:0] = sync_ctrl_ff;
    else if (a == ADDR_SW_SELECT)
      v[15:0] = sw_select_ff;
    else if (a == ADDR_BANK_CFG)
      v[1:0] = bank_cfg_ff;
    else if (a == ADDR_ENABLE)
      v[ENABLE_BIT] = enable_ff;
    else if (a == ADDR_SW_SYNC)
      v[SW_SYNC_BIT] = sw_sync_ff; // R19
    else if (a == ADDR_STATUS)
    begin
      v[STAT_A_LSB +: SEL_W] = a_sel_ff;
      v[STAT_B_LSB +: SEL_W] = b_sel_ff;
      v[STAT_ARM_BIT]        = (sync_state_ff != SYNC_IDLE);
    end
    return v;
  endfunction

  // Bus phase tracking and read data, captured in the address phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 14'h0000;
      hrdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr_ff <= {haddr[13:2], 2'h0};
      if (addr_ok && !hwrite)
        hrdata_ff <= read_value({haddr[13:2], 2'h0});
    end
  end

  // Register writes land at the end of the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_ctrl_ff <= RST_SYNC_CTRL;
      sw_select_ff <= RST_SW_SELECT;
      bank_cfg_ff  <= RST_BANK_CFG;
      enable_ff    <= RST_ENABLE;
      sw_sync_ff   <= RST_SW_SYNC;
      sync_fire_ff <= 1'b0;
    end
    else
    begin
      sync_fire_ff <= 1'b0;
      if (wr_pend_ff)
      begin
        if (wr_addr_ff == ADDR_SYNC_CTRL)
        begin
          sync_ctrl_ff <= 8'h00;
          sync_ctrl_ff[SRC_B_BIT] <= hwdata[SRC_B_BIT];
          sync_ctrl_ff[SRC_A_BIT] <= hwdata[SRC_A_BIT];
          sync_ctrl_ff[PHASE_SRC_LSB +: 2] <= hwdata[PHASE_SRC_LSB +: 2];
        end
        else if (wr_addr_ff == ADDR_SW_SELECT)
        begin
          sw_select_ff <= 16'h0000;
          sw_select_ff[SEL_B_LSB +: SEL_W] <= hwdata[SEL_B_LSB +: SEL_W]; // R9
          sw_select_ff[SEL_A_LSB +: SEL_W] <= hwdata[SEL_A_LSB +: SEL_W]; // R10
        end
        else if (wr_addr_ff == ADDR_BANK_CFG)
          bank_cfg_ff <= hwdata[1:0];
        else if (wr_addr_ff == ADDR_ENABLE)
          enable_ff <= hwdata[ENABLE_BIT]; // R14
        else if (wr_addr_ff == ADDR_SW_SYNC)
        begin
          sw_sync_ff   <= hwdata[SW_SYNC_BIT]; // R19
          sync_fire_ff <= hwdata[SW_SYNC_BIT] && !sw_sync_ff; // R19
        end
      end
    end
  end

  // Accumulator selection for oscillator A.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      a_sel_ff <= RST_ACC_SEL;
    else if (!enable_ff)
      a_sel_ff <= RST_ACC_SEL; // R14
    else if (!src_a)
      a_sel_ff <= sw_select_ff[SEL_A_LSB +: SEL_W]; // R3
    else if (strobe_rise) // R4
    begin
      if (bank_cfg_ff == BANK_SPLIT)
        a_sel_ff <= {1'b0, idx_s}; // R11
      else if (bank_cfg_ff == BANK_SHARED)
        a_sel_ff <= {bank_s, idx_s}; // R12
      else if (bank_cfg_ff == BANK_STEER && !bank_s)
        a_sel_ff <= {1'b0, idx_s}; // R13
    end
  end

  // Accumulator selection for oscillator B.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      b_sel_ff <= RST_ACC_SEL;
    else if (!enable_ff)
      b_sel_ff <= RST_ACC_SEL; // R14
    else if (!src_b)
      b_sel_ff <= sw_select_ff[SEL_B_LSB +: SEL_W]; // R1
    else if (strobe_rise) // R2
    begin
      if (bank_cfg_ff == BANK_SPLIT)
        b_sel_ff <= {1'b1, idx_s}; // R11
      else if (bank_cfg_ff == BANK_SHARED)
        b_sel_ff <= {bank_s, idx_s}; // R12
      else if (bank_cfg_ff == BANK_STEER && bank_s)
        b_sel_ff <= {1'b1, idx_s}; // R13
    end
  end

  // Sync arming. A new pulse re-arms, so an edge in the same cycle is not used.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_state_ff <= SYNC_IDLE;
      acc_reset_ff  <= 1'b1;
    end
    else if (!enable_ff)
    begin
      sync_state_ff <= SYNC_IDLE;
      acc_reset_ff  <= 1'b1; // R14
    end
    else
    begin
      acc_reset_ff <= 1'b0;
      if (sync_fire_ff)
      begin
        if (phase_src == PHASE_IMMEDIATE)
          acc_reset_ff <= 1'b1; // R6
        else if (phase_src == PHASE_SYSREF)
          sync_state_ff <= SYNC_WAIT_SYSREF; // R7
        else if (phase_src == PHASE_TRIGGER)
          sync_state_ff <= SYNC_WAIT_TRIG; // R8
      end
      else
      begin
        case (sync_state_ff)
          SYNC_WAIT_SYSREF:
            if (sysref_rise)
            begin
              acc_reset_ff  <= 1'b1; // R7
              sync_state_ff <= SYNC_IDLE;
            end
          SYNC_WAIT_TRIG:
            if (strobe_rise && bank_s)
            begin
              acc_reset_ff  <= 1'b1; // R8
              sync_state_ff <= SYNC_IDLE;
            end
          default:
            sync_state_ff <= SYNC_IDLE;
        endcase
      end
    end
  end

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = hrdata_ff;
  assign osc_a_acc_sel = a_sel_ff;
  assign osc_b_acc_sel = b_sel_ff;
  assign acc_reset     = acc_reset_ff;

  sw_follow_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    enable_ff && $past(enable_ff) && !src_a && $stable(sw_select_ff)
    |-> a_sel_ff == sw_select_ff[SEL_A_LSB +: SEL_W])
    else $error("A does not follow software index");
  b_sw_follow_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    enable_ff && $past(enable_ff) && !src_b && $stable(sw_select_ff)
    |-> b_sel_ff == sw_select_ff[SEL_B_LSB +: SEL_W])
    else $error("B does not follow software index");

  shared_bank_a: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    enable_ff && src_a && src_b && bank_cfg_ff == BANK_SHARED && strobe_rise
    |=> a_sel_ff == {$past(bank_s), $past(idx_s)} && b_sel_ff == a_sel_ff)
    else $error("Shared bank selection wrong");

  split_bank_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    enable_ff && src_b && bank_cfg_ff == BANK_SPLIT && strobe_rise
    |=> b_sel_ff == {1'b1, $past(idx_s)})
    else $error("Split bank selection wrong");

  steer_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    enable_ff && src_a && bank_cfg_ff == BANK_STEER && strobe_rise && bank_s
    |=> $stable(a_sel_ff))
    else $error("Steered strobe changed the other oscillator");

  no_strobe_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    enable_ff && src_a && !strobe_rise ##1 enable_ff && src_a |-> $stable(a_sel_ff))
    else $error("External selection changed without a strobe");

  immediate_rst_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    enable_ff && sync_fire_ff && phase_src == PHASE_IMMEDIATE
    |=> acc_reset_ff ##1 !acc_reset_ff || !enable_ff)
    else $error("Immediate sync did not pulse reset");

  sysref_wait_a: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    enable_ff && sync_state_ff == SYNC_WAIT_SYSREF && !sync_fire_ff
    |=> (acc_reset_ff == $past(sysref_rise)) || !enable_ff)
    else $error("Armed reset not tied to SYSREF edge");

  trig_wait_a: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    enable_ff && sync_state_ff == SYNC_WAIT_TRIG && !sync_fire_ff
    |=> (acc_reset_ff == $past(strobe_rise && bank_s)) || !enable_ff)
    else $error("Armed reset not tied to strobe with bank high");

  disable_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    !enable_ff |=> acc_reset_ff && a_sel_ff == RST_ACC_SEL && b_sel_ff == RST_ACC_SEL
    && sync_state_ff == SYNC_IDLE)
    else $error("Disabled oscillator logic not held in reset");

  repeat_sync_a: assert property (@(posedge hclk) disable iff (!hresetn) // R19
    wr_pend_ff && wr_addr_ff == ADDR_SW_SYNC && sw_sync_ff |=> !sync_fire_ff)
    else $error("Writing one over one fired a sync");
  ahb_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("Slave inserted wait or error");

  sysref_rst_c: cover property (@(posedge hclk) disable iff (!hresetn)
    sync_state_ff == SYNC_WAIT_SYSREF ##1 acc_reset_ff && enable_ff);
  trig_rst_c: cover property (@(posedge hclk) disable iff (!hresetn)
    sync_state_ff == SYNC_WAIT_TRIG ##1 acc_reset_ff && enable_ff);
  shared_sel_c: cover property (@(posedge hclk) disable iff (!hresetn)
    enable_ff && src_a && bank_cfg_ff == BANK_SHARED && strobe_rise && bank_s);

endmodule // oscillator_select_sync_ctrl

// file: testbench/ext_select_driver.sv
// Purpose: Far-side logic that drives the select pins, trigger strobe and SYSREF.
// Assumes: The block samples every pin asynchronously.
// Notes:   Index and bank always move on the same edge as the strobe rise.
`timescale 1ns/1ps
module ext_select_driver (
  // Clock
  input  wire logic       hclk,
  // Pins
  output logic      [3:0] ext_select_index,
  output logic            ext_bank_select,
  output logic            ext_select_strobe,
  output logic            sysref
);
  initial
  begin
    ext_select_index  = 4'h0;
    ext_bank_select   = 1'b0;
    ext_select_strobe = 1'b0;
    sysref            = 1'b0;
  end

  // Hold sets how slow the pulse is; the block needs one cycle high and one low.
  task automatic strobe_sel(input logic [3:0] idx, input logic bnk, input int hold);
    @(posedge hclk);
    ext_select_index  <= idx;
    ext_bank_select   <= bnk;
    ext_select_strobe <= 1'b1;
    repeat (hold) @(posedge hclk);
    ext_select_strobe <= 1'b0;
    repeat (hold) @(posedge hclk);
  endtask

  task automatic sysref_pulse(input int hold);
    @(posedge hclk);
    sysref <= 1'b1;
    repeat (hold) @(posedge hclk);
    sysref <= 1'b0;
    repeat (hold) @(posedge hclk);
  endtask
endmodule // ext_select_driver

// file: testbench/oscillator_select_sync_ctrl_test.sv
// Purpose: Self-checking bench for the oscillator select and sync control block.
// Assumes: One AHB-Lite master issues single word transfers with an idle cycle between.
// Notes:   Accumulator resets are counted per clock whenever acc_reset is high, enabled or not.
`timescale 1ns/1ps
module oscillator_select_sync_ctrl_test;
  import osc_sel_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  ext_select_index;
  logic        ext_bank_select, ext_select_strobe, sysref, acc_reset;
  logic [4:0]  osc_a_acc_sel, osc_b_acc_sel;
  int          err_total, num_checks, cycles, pulses;

  oscillator_select_sync_ctrl i_oscillator_select_sync_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_select_index(ext_select_index), .ext_bank_select(ext_bank_select),
    .ext_select_strobe(ext_select_strobe), .sysref(sysref),
    .osc_a_acc_sel(osc_a_acc_sel), .osc_b_acc_sel(osc_b_acc_sel), .acc_reset(acc_reset));

  ext_select_driver i_ext_select_driver (
    .hclk(hclk), .ext_select_index(ext_select_index), .ext_bank_select(ext_bank_select),
    .ext_select_strobe(ext_select_strobe), .sysref(sysref));

  // A single slave, so its ready is the bus ready.
  assign hready = hreadyout;

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // The whole run needs about 450 cycles.
  always @(posedge hclk)
  begin
    cycles = cycles + 1;
    if (acc_reset === 1'b1)
      pulses = pulses + 1;
    if (cycles == 20000)
    begin
      err_total = err_total + 1;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {18'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    chk({30'h0, hreadyout, hresp}, 32'h2, "response");
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, e, "read");
  endtask

  // Configuration is only changed with the oscillators stopped.
  task automatic cfg(input logic [7:0] sc, input logic [1:0] bm);
    wr(ADDR_ENABLE, 32'h0);
    wr(ADDR_SYNC_CTRL, {24'h0, sc});
    wr(ADDR_BANK_CFG, {30'h0, bm});
    wr(ADDR_ENABLE, 32'h1);
    repeat (4) @(posedge hclk);
    @(negedge hclk) pulses = 0;
  endtask

  task automatic sel_chk(input logic [4:0] a, input logic [4:0] b);
    repeat (4) @(posedge hclk);
    chk({27'h0, osc_a_acc_sel}, {27'h0, a}, "sel a");
    chk({27'h0, osc_b_acc_sel}, {27'h0, b}, "sel b");
  endtask

  task automatic pulse_chk(input int n);
    repeat (8) @(posedge hclk);
    chk(pulses, n, "reset pulses");
    @(negedge hclk) pulses = 0;
  endtask

  task automatic fire();
    wr(ADDR_SW_SYNC, 32'h0);
    wr(ADDR_SW_SYNC, 32'h1);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    err_total = 0;
    num_checks = 0;
    cycles = 0;
    pulses = 0;
    repeat (12) @(posedge hclk);
    chk({31'h0, acc_reset}, 32'h1, "reset held");
    hresetn <= 1'b1;
    rd(ADDR_SYNC_CTRL, 32'h0);
    rd(ADDR_SW_SELECT, 32'h0);
    rd(ADDR_BANK_CFG, 32'h0);
    rd(ADDR_ENABLE, 32'h0);
    rd(ADDR_SW_SYNC, 32'h0);
    wr(ADDR_SYNC_CTRL, 32'hFFFF_FFFF);
    rd(ADDR_SYNC_CTRL, 32'h33);
    wr(ADDR_SW_SELECT, 32'hFFFF_FFFF);
    rd(ADDR_SW_SELECT, 32'h1F1F);
    wr(ADDR_BANK_CFG, 32'hFFFF_FFFF);
    rd(ADDR_BANK_CFG, 32'h3);
    wr(14'h0C44, 32'hFFFF_FFFF);
    rd(14'h0C44, 32'h0);
    wr(ADDR_SW_SELECT, 32'h150A);
    wr(ADDR_SW_SYNC, 32'h1);
    rd(ADDR_SW_SYNC, 32'h1);
    cfg(8'h00, BANK_SPLIT);
    sel_chk(5'h0A, 5'h15);
    chk({31'h0, acc_reset}, 32'h0, "running");
    cfg(8'h20, BANK_SPLIT);
    i_ext_select_driver.strobe_sel(4'h6, 1'b1, 2);
    sel_chk(5'h0A, 5'h16);
    cfg(8'h30, BANK_SPLIT);
    i_ext_select_driver.strobe_sel(4'h9, 1'b0, 3);
    sel_chk(5'h09, 5'h19);
    cfg(8'h30, BANK_SHARED);
    i_ext_select_driver.strobe_sel(4'hC, 1'b1, 2);
    sel_chk(5'h1C, 5'h1C);
    i_ext_select_driver.strobe_sel(4'h3, 1'b0, 4);
    sel_chk(5'h03, 5'h03);
    cfg(8'h30, BANK_STEER);
    i_ext_select_driver.strobe_sel(4'h7, 1'b0, 2);
    sel_chk(5'h07, 5'h00);
    i_ext_select_driver.strobe_sel(4'hE, 1'b1, 2);
    sel_chk(5'h07, 5'h1E);
    wr(ADDR_ENABLE, 32'h0);
    i_ext_select_driver.strobe_sel(4'h2, 1'b1, 2);
    sel_chk(5'h00, 5'h00);
    chk({31'h0, acc_reset}, 32'h1, "stopped");
    cfg(8'h30, 2'h3);
    i_ext_select_driver.strobe_sel(4'h5, 1'b1, 2);
    sel_chk(5'h00, 5'h00);
    cfg(8'h00, BANK_SPLIT);
    fire();
    pulse_chk(1);
    wr(ADDR_SW_SYNC, 32'h1);
    pulse_chk(0);
    cfg(8'h01, BANK_SPLIT);
    fire();
    pulse_chk(0);
    rd(ADDR_STATUS, 32'h0001_150A);
    i_ext_select_driver.sysref_pulse(2);
    pulse_chk(1);
    i_ext_select_driver.sysref_pulse(3);
    pulse_chk(0);
    cfg(8'h02, BANK_SPLIT);
    fire();
    i_ext_select_driver.strobe_sel(4'h1, 1'b0, 2);
    pulse_chk(0);
    i_ext_select_driver.strobe_sel(4'h1, 1'b1, 2);
    pulse_chk(1);
    cfg(8'h03, BANK_SPLIT);
    fire();
    i_ext_select_driver.sysref_pulse(2);
    i_ext_select_driver.strobe_sel(4'h1, 1'b1, 2);
    pulse_chk(0);
    conclude();
  end
endmodule // oscillator_select_sync_ctrl_test
